// >>> hw/pfs_pkg.sv
/*
  constants and types for the per-port function sequencer.
  assumes a 40 mhz ref_clk; times are scaled to cycles here.
*/
package pfs_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  // times in microseconds, as printed
  localparam int unsigned SETTLE_US = 5000;
  localparam int unsigned CONV_US = 18000;
  localparam int unsigned RAMP_US = 500;
  localparam int unsigned SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CONV_CYC = CONV_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RAMP_CYC = RAMP_US * (CLK_HZ / 1_000_000);
  // conversion phases split of the total conversion time
  localparam int unsigned PRE_CYC = CONV_CYC / 8;
  localparam int unsigned CHG_CYC = CONV_CYC / 2;
  localparam int unsigned CRS_CYC = CONV_CYC / 4;
  localparam int unsigned FIN_CYC = CONV_CYC - PRE_CYC - CHG_CYC - CRS_CYC;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned RES_W = 15;
  localparam int unsigned CS_SAMPLES = 31;
  localparam logic [RES_W-1:0] RES_RST = 15'h0000;

  typedef enum logic [3:0] {
    PFS_FN_DISABLE = 4'h0,
    PFS_FN_DET1 = 4'h1,
    PFS_FN_DET2 = 4'h2,
    PFS_FN_VSAMP = 4'h3,
    PFS_FN_LEGACY = 4'h4,
    PFS_FN_CLASS = 4'h5,
    PFS_FN_RAMP = 4'h6,
    PFS_FN_CSAMP = 4'h7
  } pfs_fn_t;

  // port test condition driven to the analog front end
  typedef enum logic [2:0] {
    PFS_CND_OFF = 3'h0,
    PFS_CND_DET1 = 3'h1,
    PFS_CND_DET2 = 3'h2,
    PFS_CND_DIFF = 3'h3,
    PFS_CND_LEGACY = 3'h4,
    PFS_CND_CLASS = 3'h5,
    PFS_CND_POWER = 3'h6
  } pfs_cnd_t;

  // conversion phases, gray coded along the path
  typedef enum logic [2:0] {
    PFS_AD_IDLE = 3'b000,
    PFS_AD_PRE = 3'b001,
    PFS_AD_CHG = 3'b011,
    PFS_AD_CRS = 3'b010,
    PFS_AD_FIN = 3'b110,
    PFS_AD_END = 3'b111
  } pfs_ad_t;
endpackage : pfs_pkg

// >>> hw/pfs_adc_seq.sv
/*
  phase sequencer for one integrating conversion.
  assumes start is a one-cycle pulse and the count input is steady while busy.
*/
module pfs_adc_seq
  import pfs_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYC // whole conversion in cycles
) (
  input wire logic ref_clk, // clock
  input wire logic rst, // sync reset, high
  input wire logic start, // start pulse
  input wire logic abort, // drop conversion
  input wire logic [RES_W-1:0] sample, // front end count
  output pfs_pkg::pfs_ad_t phase, // current phase
  output logic done, // one-cycle end pulse
  output logic [RES_W-1:0] result // captured count
);
  pfs_ad_t ph_reg, ph_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic [RES_W-1:0] res_reg, res_next;

  // phase split: an eighth, a half, a quarter, then the rest; needs 8 cycles or more
  localparam int unsigned PRE_LEN = CONV_CYCLES / 8;
  localparam int unsigned CHG_LEN = CONV_CYCLES / 2;
  localparam int unsigned CRS_LEN = CONV_CYCLES / 4;
  localparam int unsigned FIN_LEN = CONV_CYCLES - PRE_LEN - CHG_LEN - CRS_LEN;

  function automatic logic [CNT_W-1:0] phase_len(input pfs_ad_t p);
    case (p)
      PFS_AD_PRE: phase_len = CNT_W'(PRE_LEN);
      PFS_AD_CHG: phase_len = CNT_W'(CHG_LEN);
      PFS_AD_CRS: phase_len = CNT_W'(CRS_LEN);
      PFS_AD_FIN: phase_len = CNT_W'(FIN_LEN);
      default: phase_len = CNT_W'(1);
    endcase
  endfunction : phase_len

  // phase walk: precharge, charge, coarse, fine
  always_comb begin
    ph_next = ph_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    res_next = res_reg;
    if (abort) begin
      ph_next = PFS_AD_IDLE;
    end else begin
      case (ph_reg)
        PFS_AD_IDLE: begin
          if (start) begin
            ph_next = PFS_AD_PRE;
            cnt_next = phase_len(PFS_AD_PRE) - CNT_W'(1);
          end
        end
        PFS_AD_PRE, PFS_AD_CHG, PFS_AD_CRS, PFS_AD_FIN: begin
          if (cnt_reg != '0) begin
            cnt_next = cnt_reg - CNT_W'(1);
          end else begin
            case (ph_reg)
              PFS_AD_PRE: ph_next = PFS_AD_CHG;
              PFS_AD_CHG: ph_next = PFS_AD_CRS;
              PFS_AD_CRS: ph_next = PFS_AD_FIN;
              default: ph_next = PFS_AD_END;
            endcase
            cnt_next = phase_len(ph_next) - CNT_W'(1);
          end
        end
        PFS_AD_END: begin
          ph_next = PFS_AD_IDLE;
          done_next = 1'b1;
          res_next = sample;
        end
        default: ph_next = PFS_AD_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ph_reg <= PFS_AD_IDLE;
      cnt_reg <= '0;
      done_reg <= 1'b0;
      res_reg <= RES_RST;
    end else begin
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      res_reg <= res_next;
    end
  end

  assign phase = ph_reg;
  assign done = done_reg;
  assign result = res_reg;

  ad_order_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ph_reg == PFS_AD_PRE && ph_next != PFS_AD_PRE && !abort) |=> ph_reg == PFS_AD_CHG)
    else $error("precharge not followed by charge");
  ad_fine_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(ph_reg == PFS_AD_FIN) |-> $past(ph_reg) == PFS_AD_CRS)
    else $error("fine discharge entered out of order");
endmodule : pfs_adc_seq

// >>> hw/pfs_port_seq.sv
/*
  per-port function sequencer: decodes a four-bit function code, applies
  the port condition, runs timed conversions, stores results, flags done.
  assumes the host serial block delivers fn_valid with fn_code in one cycle
  and an outside arbiter or the host grants classification.
*/
module pfs_port_seq
  import pfs_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC, // settle time in cycles
  parameter int unsigned RAMP_CYCLES = RAMP_CYC, // ramp time in cycles
  parameter int unsigned CONV_CYCLES = CONV_CYC // conversion time in cycles
) (
  input wire logic ref_clk, // 40 mhz clock
  input wire logic rst, // sync reset, high
  input wire logic fn_valid, // function call strobe
  input wire logic [3:0] fn_code, // function code
  input wire logic autonomous_mode, // serialised classify needed
  input wire logic class_grant, // classify slot free
  input wire logic [RES_W-1:0] ad_sample, // front end count
  output pfs_pkg::pfs_cnd_t port_cond, // applied test condition
  output logic [7:0] output_current_limit, // ramp current level
  output logic power_on, // port powered latch
  output logic class_busy, // holds classify slot
  output logic conv_busy, // conversion running
  output logic fn_done, // function done flag
  output logic [RES_W:0] det_current, // done bit + detection current
  output logic [RES_W:0] port_current, // done bit + port current
  output logic [RES_W:0] port_voltage // done bit + port voltage
);
  typedef enum logic [2:0] {
    PFS_ST_IDLE = 3'b000,
    PFS_ST_WAIT = 3'b001,
    PFS_ST_SETTLE = 3'b011,
    PFS_ST_CONV = 3'b010,
    PFS_ST_RAMP = 3'b110
  } pfs_st_t;

  pfs_st_t st_reg, st_next;
  pfs_fn_t fn_reg, fn_next;
  pfs_cnd_t cnd_reg, cnd_next;
  logic [CNT_W-1:0] tmr_reg, tmr_next;
  logic [4:0] cs_reg, cs_next;
  logic [7:0] ilim_reg, ilim_next;
  logic pwr_reg, pwr_next;
  logic done_reg, done_next;
  logic cls_reg, cls_next;
  logic [RES_W:0] det_reg, det_next, cur_reg, cur_next, vol_reg, vol_next;
  logic ad_start;
  logic ad_done;
  logic [RES_W-1:0] ad_res;
  pfs_ad_t ad_phase;
  logic ad_abort;
  logic busy_reg, busy_next;

  // condition each function applies
  function automatic pfs_cnd_t fn_cond(input pfs_fn_t f);
    case (f)
      PFS_FN_DET1: fn_cond = PFS_CND_DET1;
      PFS_FN_DET2: fn_cond = PFS_CND_DET2;
      PFS_FN_VSAMP, PFS_FN_CSAMP: fn_cond = PFS_CND_DIFF;
      PFS_FN_LEGACY: fn_cond = PFS_CND_LEGACY;
      PFS_FN_CLASS: fn_cond = PFS_CND_CLASS;
      PFS_FN_RAMP: fn_cond = PFS_CND_POWER;
      default: fn_cond = PFS_CND_OFF;
    endcase
  endfunction : fn_cond

  // only an accepted call drops a running conversion; ignored codes leave it
  assign ad_abort = fn_valid && !fn_code[3];

  pfs_adc_seq #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_adc (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(ad_start),
    .abort(ad_abort),
    .sample(ad_sample),
    .phase(ad_phase),
    .done(ad_done),
    .result(ad_res)
  );

  // function sequencing
  always_comb begin
    st_next = st_reg;
    fn_next = fn_reg;
    cnd_next = cnd_reg;
    tmr_next = tmr_reg;
    cs_next = cs_reg;
    ilim_next = ilim_reg;
    pwr_next = pwr_reg;
    done_next = done_reg;
    cls_next = cls_reg;
    det_next = det_reg;
    cur_next = cur_reg;
    vol_next = vol_reg;
    ad_start = 1'b0;
    if (fn_valid && fn_code[3] == 1'b0) begin
      // new call: clear done, drop classify slot, latch code
      fn_next = pfs_fn_t'(fn_code[2:0] == 3'h0 ? 4'h0 : {1'b0, fn_code[2:0]});
      done_next = 1'b0;
      cls_next = 1'b0;
      cs_next = '0;
      st_next = PFS_ST_WAIT;
      if (fn_next != PFS_FN_RAMP && fn_next != PFS_FN_CSAMP) begin
        pwr_next = 1'b0;
        ilim_next = '0;
      end
    end else begin
      case (st_reg)
        PFS_ST_IDLE: st_next = PFS_ST_IDLE; // wait for next call
        PFS_ST_WAIT: begin
          if (fn_reg == PFS_FN_CLASS && autonomous_mode && !class_grant) begin
            st_next = PFS_ST_WAIT;
          end else begin
            cnd_next = fn_cond(fn_reg);
            cls_next = (fn_reg == PFS_FN_CLASS);
            case (fn_reg)
              PFS_FN_DISABLE: begin
                done_next = 1'b1;
                st_next = PFS_ST_IDLE;
              end
              PFS_FN_DET1, PFS_FN_DET2: begin
                tmr_next = CNT_W'(SETTLE_CYCLES - 1);
                st_next = PFS_ST_SETTLE;
              end
              PFS_FN_RAMP: begin
                tmr_next = CNT_W'(RAMP_CYCLES - 1);
                ilim_next = '0;
                st_next = PFS_ST_RAMP;
              end
              default: begin
                ad_start = 1'b1;
                st_next = PFS_ST_CONV;
              end
            endcase
          end
        end
        PFS_ST_SETTLE: begin
          if (tmr_reg != '0) begin
            tmr_next = tmr_reg - CNT_W'(1);
          end else begin
            ad_start = 1'b1;
            st_next = PFS_ST_CONV;
          end
        end
        PFS_ST_CONV: begin
          if (ad_done) begin
            case (fn_reg)
              PFS_FN_DET1, PFS_FN_DET2: det_next = {1'b1, ad_res};
              PFS_FN_CLASS: cur_next = {1'b1, ad_res};
              PFS_FN_CSAMP: begin
                if (cs_reg == 5'(CS_SAMPLES)) begin
                  vol_next = {1'b1, ad_res};
                end else begin
                  cur_next = {1'b1, ad_res};
                end
              end
              default: vol_next = {1'b1, ad_res};
            endcase
            if (fn_reg == PFS_FN_CSAMP) begin
              // continuous: restart, done set after each full round
              cs_next = (cs_reg == 5'(CS_SAMPLES)) ? 5'h00 : cs_reg + 5'h01;
              done_next = done_reg | (cs_reg == 5'(CS_SAMPLES));
              ad_start = 1'b1;
            end else begin
              done_next = 1'b1;
              cls_next = 1'b0;
              st_next = PFS_ST_IDLE;
            end
          end
        end
        PFS_ST_RAMP: begin
          if (tmr_reg != '0) begin
            tmr_next = tmr_reg - CNT_W'(1);
            ilim_next = 8'((CNT_W'(RAMP_CYCLES) - tmr_reg) * 255 / RAMP_CYCLES);
          end else begin
            ilim_next = 8'hff;
            pwr_next = 1'b1;
            done_next = 1'b1;
            st_next = PFS_ST_IDLE;
          end
        end
        default: st_next = PFS_ST_IDLE;
      endcase
      if (fn_reg != PFS_FN_DISABLE && fn_next == fn_reg && st_next == PFS_ST_IDLE) begin
        cnd_next = cnd_reg;
      end
    end
    // busy kept in a flop so conv_busy leaves the block registered
    busy_next = (st_next == PFS_ST_CONV);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= PFS_ST_IDLE;
      fn_reg <= PFS_FN_DISABLE;
      cnd_reg <= PFS_CND_OFF;
      tmr_reg <= '0;
      cs_reg <= '0;
      ilim_reg <= '0;
      pwr_reg <= 1'b0;
      done_reg <= 1'b0;
      cls_reg <= 1'b0;
      det_reg <= '0;
      cur_reg <= '0;
      vol_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      fn_reg <= fn_next;
      cnd_reg <= cnd_next;
      tmr_reg <= tmr_next;
      cs_reg <= cs_next;
      ilim_reg <= ilim_next;
      pwr_reg <= pwr_next;
      done_reg <= done_next;
      cls_reg <= cls_next;
      det_reg <= det_next;
      cur_reg <= cur_next;
      vol_reg <= vol_next;
      busy_reg <= busy_next;
    end
  end

  assign port_cond = cnd_reg;
  assign output_current_limit = ilim_reg;
  assign power_on = pwr_reg;
  assign class_busy = cls_reg;
  assign conv_busy = busy_reg;
  assign fn_done = done_reg;
  assign det_current = det_reg;
  assign port_current = cur_reg;
  assign port_voltage = vol_reg;

  call_clears_done_a: assert property (@(posedge ref_clk) disable iff (rst)
    (fn_valid && !fn_code[3]) |=> !fn_done)
    else $error("done not cleared by new call");
  disable_done_a: assert property (@(posedge ref_clk) disable iff (rst)
    (fn_valid && fn_code == 4'h0) ##1 !fn_valid |=> fn_done)
    else $error("disable did not finish in two cycles");
  settle_no_conv_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == PFS_ST_SETTLE && tmr_reg != '0) |-> ad_phase == PFS_AD_IDLE)
    else $error("conversion started during settling");
  det_store_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ad_done && st_reg == PFS_ST_CONV && !fn_valid
      && (fn_reg == PFS_FN_DET1 || fn_reg == PFS_FN_DET2))
    |=> det_current == {1'b1, $past(ad_res)} && fn_done)
    else $error("detection result not stored with done");
  det_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (fn_reg != PFS_FN_DET1 && fn_reg != PFS_FN_DET2) |=> $stable(det_current))
    else $error("detection result changed by other function");
  cond_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == PFS_ST_IDLE && !fn_valid) |=> $stable(port_cond))
    else $error("port condition changed without a call");
  class_store_a: assert property (@(posedge ref_clk) disable iff (rst)
    (fn_reg != PFS_FN_CLASS && fn_reg != PFS_FN_CSAMP) |=> $stable(port_current))
    else $error("port current changed by other function");
  class_solo_a: assert property (@(posedge ref_clk) disable iff (rst)
    (autonomous_mode && !class_grant && st_reg == PFS_ST_WAIT && fn_reg == PFS_FN_CLASS
      && !fn_valid) |=> !class_busy)
    else $error("classify began without the slot");
  ramp_power_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(power_on) |-> output_current_limit == 8'hff && fn_done)
    else $error("power latched before ramp reached limit");
  legacy_store_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ad_done && st_reg == PFS_ST_CONV && !fn_valid && fn_reg == PFS_FN_LEGACY)
    |=> port_voltage == {1'b1, $past(ad_res)})
    else $error("legacy voltage not stored");
  ignore_code_a: assert property (@(posedge ref_clk) disable iff (rst)
    (fn_valid && fn_code[3]) |=> $stable(fn_reg))
    else $error("ignored code changed the function");
  ramp_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == PFS_ST_RAMP && !fn_valid) |=> output_current_limit >= $past(output_current_limit))
    else $error("ramp current fell");
  settle_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == PFS_ST_SETTLE && tmr_reg == '0 && !fn_valid) |=> conv_busy && ad_phase == PFS_AD_PRE)
    else $error("conversion did not start after settling");

  det_run_c: cover property (@(posedge ref_clk) fn_reg == PFS_FN_DET1 && $rose(fn_done));
  class_run_c: cover property (@(posedge ref_clk) fn_reg == PFS_FN_CLASS && $rose(fn_done));
  ramp_run_c: cover property (@(posedge ref_clk) $rose(power_on));
  csamp_run_c: cover property (@(posedge ref_clk) fn_reg == PFS_FN_CSAMP && $rose(fn_done));
  ignore_run_c: cover property (@(posedge ref_clk) fn_valid && fn_code[3] && conv_busy);
endmodule : pfs_port_seq

// >>> bench/pfs_host_model.sv
/*
  host side model: issues one function call at a time and polls done.
  assumes the port samples fn_valid and fn_code on the rising edge.
*/
module pfs_host_model (
  input wire logic ref_clk, // clock
  input wire logic rst, // sync reset, high
  input wire logic fn_done, // done flag from the port
  output logic fn_valid, // call strobe
  output logic [3:0] fn_code // function code
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle before the first call
  initial begin
    fn_valid = 1'b0;
    fn_code = 4'h0;
  end

  // one port only, so classify never runs on two ports at once
  task call(input logic [3:0] code);
    @(negedge ref_clk);
    fn_valid = 1'b1;
    fn_code = code;
    @(negedge ref_clk);
    fn_valid = 1'b0;
    fn_code = ~code; // stale code must not matter once released
  endtask : call

  // poll done before using a result or calling again
  task wait_done(output bit ok);
    ok = 1'b0;
    repeat (2) @(negedge ref_clk);
    // a full continuous round is the slowest call and fits well inside
    for (int i = 0; i < 2000 && !ok; i++) begin
      @(negedge ref_clk);
      if (fn_done === 1'b1 && rst === 1'b0) ok = 1'b1;
    end
  endtask : wait_done
endmodule : pfs_host_model

// >>> bench/pfs_port_seq_tb.sv
/*
  testbench for the port function sequencer: calls, aborts, arbitration.
  assumes the host model in this folder and shortened settle, ramp and conversion.
*/
module pfs_port_seq_tb;
  import pfs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned SETTLE_T = 10;
  localparam int unsigned RAMP_T = 10;
  localparam int unsigned CONV_T = 40;
  typedef struct packed {
    pfs_cnd_t cond; // condition at done
    logic pwr; // power latch at done
    logic [1:0] sel; // result to look at: 1 det, 2 current, 3 voltage
    logic [RES_W:0] res; // expected result word
  } pfs_note_t;

  logic ref_clk, rst, fn_valid, autonomous_mode, class_grant;
  logic [3:0] fn_code;
  logic [RES_W-1:0] ad_sample;
  pfs_cnd_t port_cond;
  logic [7:0] output_current_limit;
  logic power_on, class_busy, conv_busy, fn_done, done_seen;
  logic [RES_W:0] det_current, port_current, port_voltage;
  pfs_note_t notes[$];
  pfs_note_t got;
  int mismatches, n_checks;
  bit ok;
  logic [3:0] codes [4] = '{4'h3, 4'h4, 4'h5, 4'h7};
  pfs_cnd_t conds [4] = '{PFS_CND_DIFF, PFS_CND_LEGACY, PFS_CND_CLASS, PFS_CND_OFF};
  bit hold;
  logic [RES_W-1:0] sample_val;
  logic [RES_W:0] det_keep;
  logic [3:0] fcodes [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};
  pfs_cnd_t fconds [6] = '{PFS_CND_DET1, PFS_CND_DET2, PFS_CND_DIFF, PFS_CND_LEGACY,
    PFS_CND_CLASS, PFS_CND_DIFF};
  logic [1:0] fsels [6] = '{2'd1, 2'd1, 2'd3, 2'd3, 2'd2, 2'd3};

  pfs_port_seq #(.SETTLE_CYCLES(SETTLE_T), .RAMP_CYCLES(RAMP_T), .CONV_CYCLES(CONV_T)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .fn_valid(fn_valid), .fn_code(fn_code),
    .autonomous_mode(autonomous_mode), .class_grant(class_grant),
    .ad_sample(ad_sample), .port_cond(port_cond),
    .output_current_limit(output_current_limit), .power_on(power_on),
    .class_busy(class_busy), .conv_busy(conv_busy), .fn_done(fn_done),
    .det_current(det_current), .port_current(port_current),
    .port_voltage(port_voltage)
  );
  pfs_host_model host_u (
    .ref_clk(ref_clk), .rst(rst), .fn_done(fn_done), .fn_valid(fn_valid),
    .fn_code(fn_code)
  );

  // clock at 40 mhz
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  // front end count: random, or a held value whose result is then known
  always @(negedge ref_clk) ad_sample <= hold ? sample_val : RES_W'($urandom);

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_cyc

  // call, note the expected state and wait for done
  task call_exp(input logic [3:0] code, input pfs_cnd_t c, input logic p);
    notes.push_back('{c, p, 2'd0, '0});
    host_u.call(code);
    host_u.wait_done(ok);
    check(ok, 1'b1);
  endtask : call_exp

  // monitor: each rise of done takes the oldest note
  always @(negedge ref_clk) begin
    if (rst === 1'b0 && fn_done === 1'b1 && done_seen === 1'b0) begin
      if (notes.size() == 0) check(1'b1, 1'b0);
      else begin
        got = notes.pop_front();
        check(port_cond, got.cond);
        check(power_on, got.pwr);
        case (got.sel)
          2'd1: check(det_current, got.res);
          2'd2: check(port_current, got.res);
          2'd3: check(port_voltage, got.res);
          default: ;
        endcase
      end
    end
    done_seen <= fn_done;
  end

  // watchdog
  initial begin
    // about three times the expected run of some two thousand cycles
    #(6000 * 25);
    mismatches++;
    end_sim();
  end

  initial begin
    sample_val = RES_W'($urandom(25317)); // seeds the run once
    hold = 1'b0;
    rst = 1'b1;
    autonomous_mode = 1'b0;
    class_grant = 1'b0;
    wait_cyc(8);
    rst = 1'b0;
    check(fn_done, 1'b0);
    check(port_cond, PFS_CND_OFF);
    call_exp(4'h0, PFS_CND_OFF, 1'b0);
    // ramp-up: not yet latched mid ramp, full level at the end
    notes.push_back('{PFS_CND_POWER, 1'b1, 2'd0, '0});
    host_u.call(4'h6);
    wait_cyc(3);
    check(power_on, 1'b0);
    check(output_current_limit === 8'hff, 1'b0);
    host_u.wait_done(ok);
    check(ok, 1'b1);
    check(output_current_limit, 8'hff);
    // codes with the top bit set change nothing
    host_u.call({1'b1, 3'($urandom)});
    wait_cyc(5);
    check({fn_done, power_on}, 2'b11);
    check(port_cond, PFS_CND_POWER);
    call_exp(4'h0, PFS_CND_OFF, 1'b0);
    // first detection settles before converting
    host_u.call(4'h1);
    wait_cyc(3);
    check(fn_done, 1'b0);
    check(conv_busy, 1'b0);
    check(port_cond, PFS_CND_DET1);
    wait_cyc(SETTLE_T + 6);
    check(conv_busy, 1'b1);
    check(port_cond, PFS_CND_DET1);
    // a second detection mid conversion aborts, nothing stored
    host_u.call(4'h2);
    wait_cyc(3);
    check(det_current, 16'h0000);
    check(port_cond, PFS_CND_DET2);
    check(conv_busy, 1'b0);
    wait_cyc(SETTLE_T + 6);
    check(conv_busy, 1'b1);
    // autonomous classify waits for the slot
    autonomous_mode = 1'b1;
    host_u.call(4'h5);
    wait_cyc(20);
    check({class_busy, conv_busy, fn_done}, 3'b000);
    class_grant = 1'b1;
    wait_cyc(5);
    check({class_busy, conv_busy}, 2'b11);
    check(port_cond, PFS_CND_CLASS);
    call_exp(4'h0, PFS_CND_OFF, 1'b0);
    check(class_busy, 1'b0);
    autonomous_mode = 1'b0;
    // conversion-only functions start at once
    for (int k = 0; k < 4; k++) begin
      host_u.call(codes[k]);
      wait_cyc(5);
      check(conv_busy, 1'b1);
      if (k < 3) check(port_cond, conds[k]);
      check(port_current, 16'h0000);
    end
    call_exp(4'h0, PFS_CND_OFF, 1'b0);
    check(port_voltage, 16'h0000);
    check(notes.size(), 16'h0000);
    // full runs with a held count, an ignored code in each conversion
    hold = 1'b1;
    for (int k = 0; k < 6; k++) begin
      sample_val = RES_W'($urandom);
      notes.push_back('{fconds[k], 1'b0, fsels[k], {1'b1, sample_val}});
      if (k == 1) det_keep = {1'b1, sample_val};
      host_u.call(fcodes[k]);
      wait_cyc(15);
      host_u.call({1'b1, 3'($urandom)});
      host_u.wait_done(ok);
      check(ok, 1'b1);
      check(conv_busy, k == 5);
    end
    check(det_current, det_keep);
    check(port_current, {1'b1, sample_val});
    call_exp(4'h0, PFS_CND_OFF, 1'b0);
    check(notes.size(), 16'h0000);
    end_sim();
  end
endmodule : pfs_port_seq_tb
